//--- logic/acx_cmd_exec.sv
// Accumulator transfer, error clear and interrupt command executor
`timescale 1ns/1ns
`include "acx_consts.svh"

module acx_cmd_exec
  import acx_pkg::*;
#(
  parameter int N_MOT = 6,
  parameter int N_AXP = 8,
  parameter int N_GLB = 64,
  parameter int N_IRQ = 16,
  parameter int VEC_W = 16,
  parameter logic [7:0] DEV_ADDR = `ACX_DEV_ADDR_RST
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic [`ACX_ERR_W-1:0] err_set_i,
  input wire logic [N_IRQ-1:0] irq_src_i,
  input wire logic [VEC_W-1:0] pc_i,
  input wire logic [3:0] flags_i,
  output logic tgt_upd_o,
  output logic [7:0] tgt_motor_o,
  output logic [31:0] tgt_pos_o,
  output logic jump_o,
  output logic [VEC_W-1:0] jump_addr_o,
  output logic restore_o,
  output logic [VEC_W-1:0] restore_pc_o,
  output logic [3:0] restore_flags_o
);
  localparam int AXP_AW = $clog2(N_MOT * N_AXP);
  localparam int GLB_AW = $clog2(3 * N_GLB);
  localparam int IRQ_AW = $clog2(N_IRQ);

  acx_state_type state, next_state;
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic [31:0] hdr, next_hdr, val, next_val, accu, next_accu, xreg, next_xreg;
  logic [7:0] cks, next_cks, rep_st, next_rep_st, rep_op, next_rep_op;
  logic sa_mode, next_sa_mode, go, next_go, irq, next_irq;
  logic [`ACX_ERR_W-1:0] err, next_err;
  logic [`ACX_EV_W-1:0] ev, next_ev, mask, next_mask;
  logic [17:0] psel, next_psel;
  logic glb_en, next_glb_en, in_hdl, next_in_hdl;
  logic [N_IRQ-1:0] src_en, next_src_en, pend, next_pend, vec_ok, next_vec_ok, take;
  logic [31:0] sv_accu, next_sv_accu, sv_x, next_sv_x;
  logic [VEC_W-1:0] sv_pc, next_sv_pc;
  logic [3:0] sv_flags, next_sv_flags;
  logic tgt_upd, next_tgt_upd, jump, next_jump, restore, next_restore;
  logic [7:0] tgt_mot, next_tgt_mot;
  logic [31:0] tgt_pos, next_tgt_pos;
  logic [VEC_W-1:0] jaddr, next_jaddr, rpc, next_rpc;
  logic [3:0] rflags, next_rflags;
  logic [31:0] axp [N_MOT*N_AXP];
  logic [31:0] glb [3*N_GLB];
  logic [VEC_W-1:0] vec [N_IRQ];
  logic axp_we, glb_we, vec_we, wr, sum_ok, addr_ok, ex;
  logic [AXP_AW-1:0] axp_idx, axp_ridx;
  logic [GLB_AW-1:0] glb_idx, glb_ridx;
  logic [IRQ_AW-1:0] typ_lo, take_idx;
  logic [7:0] f_op, f_typ, f_bank;
  logic [1:0] gbank;
  logic gbank_ok, take_any;

  assign f_op = hdr[23:16];
  assign f_typ = hdr[15:8];
  assign f_bank = hdr[7:0];
  assign typ_lo = f_typ[IRQ_AW-1:0];
  assign ex = (state == ACX_EXEC);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack;

  acx_frame_chk #(
    .DEV_ADDR(DEV_ADDR)
  ) u_chk (
    .hdr_i(hdr),
    .val_i(val),
    .cks_i(cks),
    .sum_ok_o(sum_ok),
    .addr_ok_o(addr_ok)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Bank 0, 2 and 3 packed into three consecutive table slices
  always_comb begin
    gbank_ok = 1'b1;
    gbank = 2'd0;
    if (f_bank == `ACX_BANK_USER) begin
      gbank = 2'd1;
    end else if (f_bank == `ACX_BANK_IO) begin
      gbank = 2'd2;
    end else if (f_bank != `ACX_BANK_BASIC) begin
      gbank_ok = 1'b0;
    end
  end

  assign axp_idx = AXP_AW'(f_bank * N_AXP + f_typ);
  assign glb_idx = GLB_AW'(gbank * N_GLB + f_typ);
  assign axp_ridx = AXP_AW'(psel[15:8] * N_AXP + psel[7:0]);
  assign glb_ridx = GLB_AW'(psel[15:8] * N_GLB + psel[7:0]);

  // Lowest numbered ready source wins; one entry at a time, no nesting
  always_comb begin
    take_idx = '0;
    take_any = 1'b0;
    for (int i = N_IRQ - 1; i >= 0; i--) begin
      if (pend[i] & src_en[i] & vec_ok[i]) begin
        take_idx = IRQ_AW'(i);
        take_any = 1'b1;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IRQ; gi++) begin : g_pend
      // New request in the cycle of its entry is kept
      assign take[gi] = jump && (jaddr == vec[gi]) && (take_idx == IRQ_AW'(gi));
      assign next_pend[gi] = irq_src_i[gi] | (pend[gi] & ~take[gi]);
    end
  endgenerate

  // Bus answer: registered ack one cycle after the strobe, dropped next cycle
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~ack;
    next_rdat = 32'h0000_0000;
    unique case ({wb_adr_i[7:2], 2'b00})
      `ACX_REG_CTRL: next_rdat = {30'h0, sa_mode, go};
      `ACX_REG_HDR: next_rdat = hdr;
      `ACX_REG_VAL: next_rdat = val;
      `ACX_REG_CKS: next_rdat = {24'h0, cks};
      `ACX_REG_REPLY: next_rdat = {state != ACX_IDLE, 15'h0, rep_op, rep_st};
      `ACX_REG_ACCU: next_rdat = accu;
      `ACX_REG_XREG: next_rdat = xreg;
      `ACX_REG_ERR: next_rdat = 32'(err);
      `ACX_REG_IRQ_STAT: next_rdat = 32'(ev);
      `ACX_REG_IRQ_MASK: next_rdat = 32'(mask);
      `ACX_REG_INT_EN: next_rdat = {glb_en, in_hdl, 30'(src_en)};
      `ACX_REG_PSEL: next_rdat = 32'(psel);
      `ACX_REG_PDATA: begin
        if (psel[`ACX_PSEL_VEC]) begin
          if (psel[7:0] < N_IRQ) next_rdat = 32'(vec[psel[IRQ_AW-1:0]]);
        end else if (psel[`ACX_PSEL_GLB]) begin
          if (psel[15:8] < 3 && psel[7:0] < N_GLB) next_rdat = glb[glb_ridx];
        end else if (psel[15:8] < N_MOT && psel[7:0] < N_AXP) begin
          next_rdat = axp[axp_ridx];
        end
      end
      default: next_rdat = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_state = state;
    next_hdr = hdr;
    next_val = val;
    next_cks = cks;
    next_sa_mode = sa_mode;
    next_go = go;
    next_accu = accu;
    next_xreg = xreg;
    next_err = err;
    next_ev = ev;
    next_mask = mask;
    next_psel = psel;
    next_rep_st = rep_st;
    next_rep_op = rep_op;
    next_glb_en = glb_en;
    next_src_en = src_en;
    next_vec_ok = vec_ok;
    next_in_hdl = in_hdl;
    next_sv_accu = sv_accu;
    next_sv_x = sv_x;
    next_sv_pc = sv_pc;
    next_sv_flags = sv_flags;
    next_tgt_upd = 1'b0;
    next_tgt_mot = tgt_mot;
    next_tgt_pos = tgt_pos;
    next_jump = 1'b0;
    next_jaddr = jaddr;
    next_restore = 1'b0;
    next_rpc = rpc;
    next_rflags = rflags;
    axp_we = 1'b0;
    glb_we = 1'b0;
    vec_we = 1'b0;
    // Frame registers are frozen while a command is in flight
    if (wr) begin
      unique case ({wb_adr_i[7:2], 2'b00})
        `ACX_REG_CTRL: begin
          if (wb_sel_i[0]) begin
            next_sa_mode = wb_dat_i[`ACX_CTRL_SA];
            if (state == ACX_IDLE) next_go = go | wb_dat_i[`ACX_CTRL_GO];
          end
        end
        `ACX_REG_HDR: if (state == ACX_IDLE && !go) next_hdr = merge(hdr, wb_dat_i, wb_sel_i);
        `ACX_REG_VAL: if (state == ACX_IDLE && !go) next_val = merge(val, wb_dat_i, wb_sel_i);
        `ACX_REG_CKS: if (state == ACX_IDLE && !go && wb_sel_i[0]) next_cks = wb_dat_i[7:0];
        `ACX_REG_ACCU: next_accu = merge(accu, wb_dat_i, wb_sel_i);
        `ACX_REG_XREG: next_xreg = merge(xreg, wb_dat_i, wb_sel_i);
        `ACX_REG_IRQ_STAT: if (wb_sel_i[0]) next_ev = ev & ~wb_dat_i[`ACX_EV_W-1:0];
        `ACX_REG_IRQ_MASK: if (wb_sel_i[0]) next_mask = wb_dat_i[`ACX_EV_W-1:0];
        `ACX_REG_PSEL: next_psel = 18'(merge(32'(psel), wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
    unique case (state)
      ACX_IDLE: begin
        if (go) begin
          next_go = 1'b0;
          next_state = ACX_CHECK;
        end else if (sa_mode && glb_en && !in_hdl && take_any) begin
          next_sv_accu = accu;
          next_sv_x = xreg;
          next_sv_pc = pc_i;
          next_sv_flags = flags_i;
          next_in_hdl = 1'b1;
          next_jump = 1'b1;
          next_jaddr = vec[take_idx];
          next_ev[`ACX_EV_ENTRY] = 1'b1;
        end
      end
      ACX_CHECK: begin
        // Stored program steps skip the frame checks
        if (sa_mode) begin
          next_state = ACX_EXEC;
        end else if (!addr_ok) begin
          next_state = ACX_IDLE;
        end else if (!sum_ok) begin
          next_rep_st = `ACX_ST_CKSUM;
          next_rep_op = f_op;
          next_ev[`ACX_EV_CKSUM] = 1'b1;
          next_state = ACX_IDLE;
        end else begin
          next_state = ACX_EXEC;
        end
      end
      ACX_EXEC: begin
        next_state = ACX_IDLE;
        next_rep_st = `ACX_ST_OK;
        unique case (f_op)
          `ACX_OP_ACC2AXIS: begin
            if (f_bank >= N_MOT) next_rep_st = `ACX_ST_BADBANK;
            else if (f_typ >= N_AXP) next_rep_st = `ACX_ST_BADTYPE;
            else begin
              axp_we = 1'b1;
              if (f_typ == `ACX_AXP_TARGET) begin
                next_tgt_upd = 1'b1;
                next_tgt_mot = f_bank;
                next_tgt_pos = accu;
              end
            end
          end
          `ACX_OP_ACC2GLOBAL: begin
            // Value field plays no part
            if (!gbank_ok) next_rep_st = `ACX_ST_BADBANK;
            else if (f_typ >= N_GLB) next_rep_st = `ACX_ST_BADTYPE;
            else glb_we = 1'b1;
          end
          `ACX_OP_ERRCLR: begin
            if (f_typ == `ACX_CLR_ALL) next_err = '0;
            else if (f_typ <= `ACX_CLR_LAST) next_err[f_typ[2:0] - 3'd1] = 1'b0;
            else next_rep_st = `ACX_ST_BADTYPE;
          end
          `ACX_OP_IRQEN: begin
            if (f_typ == `ACX_IRQ_GLOBAL) next_glb_en = 1'b1;
            else if (f_typ < N_IRQ) next_src_en[typ_lo] = 1'b1;
            else next_rep_st = `ACX_ST_BADTYPE;
          end
          `ACX_OP_IRQDIS: begin
            if (f_typ == `ACX_IRQ_GLOBAL) next_glb_en = 1'b0;
            else if (f_typ < N_IRQ) next_src_en[typ_lo] = 1'b0;
            else next_rep_st = `ACX_ST_BADTYPE;
          end
          `ACX_OP_IRQVEC: begin
            // Accepted in direct mode as well; hosts are expected not to send it
            if (f_typ < N_IRQ) begin
              vec_we = 1'b1;
              next_vec_ok[typ_lo] = 1'b1;
            end else begin
              next_rep_st = `ACX_ST_BADTYPE;
            end
          end
          `ACX_OP_IRQRET: begin
            if (in_hdl) begin
              next_accu = sv_accu;
              next_xreg = sv_x;
              next_rpc = sv_pc;
              next_rflags = sv_flags;
              next_restore = 1'b1;
              next_in_hdl = 1'b0;
            end
          end
          default: next_rep_st = `ACX_ST_BADCMD;
        endcase
        next_rep_op = f_op;
        next_ev[`ACX_EV_DONE] = 1'b1;
        // Reply only goes out in direct mode; value field stays zero
        if (sa_mode) begin
          next_rep_st = rep_st;
          next_rep_op = rep_op;
        end
      end
    endcase
    // Hardware set of an error flag wins over a same-cycle clear
    next_err = next_err | err_set_i;
    if (|(err_set_i & ~err)) next_ev[`ACX_EV_ERR] = 1'b1;
    next_irq = |(next_ev & next_mask);
  end

  always_ff @(posedge clk_i) begin
    if (axp_we) axp[axp_idx] <= accu;
    if (glb_we) glb[glb_idx] <= accu;
    if (vec_we) vec[typ_lo] <= val[VEC_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ACX_IDLE;
      ack <= 1'b0;
      rdat <= '0;
      hdr <= '0;
      val <= '0;
      cks <= '0;
      sa_mode <= 1'b0;
      go <= 1'b0;
      accu <= '0;
      xreg <= '0;
      err <= '0;
      ev <= '0;
      mask <= '0;
      irq <= 1'b0;
      psel <= '0;
      rep_st <= '0;
      rep_op <= '0;
      glb_en <= 1'b0;
      src_en <= '0;
      pend <= '0;
      vec_ok <= '0;
      in_hdl <= 1'b0;
      sv_accu <= '0;
      sv_x <= '0;
      sv_pc <= '0;
      sv_flags <= '0;
      tgt_upd <= 1'b0;
      tgt_mot <= '0;
      tgt_pos <= '0;
      jump <= 1'b0;
      jaddr <= '0;
      restore <= 1'b0;
      rpc <= '0;
      rflags <= '0;
    end else begin
      state <= next_state;
      ack <= next_ack;
      rdat <= next_rdat;
      hdr <= next_hdr;
      val <= next_val;
      cks <= next_cks;
      sa_mode <= next_sa_mode;
      go <= next_go;
      accu <= next_accu;
      xreg <= next_xreg;
      err <= next_err;
      ev <= next_ev;
      mask <= next_mask;
      irq <= next_irq;
      psel <= next_psel;
      rep_st <= next_rep_st;
      rep_op <= next_rep_op;
      glb_en <= next_glb_en;
      src_en <= next_src_en;
      pend <= next_pend;
      vec_ok <= next_vec_ok;
      in_hdl <= next_in_hdl;
      sv_accu <= next_sv_accu;
      sv_x <= next_sv_x;
      sv_pc <= next_sv_pc;
      sv_flags <= next_sv_flags;
      tgt_upd <= next_tgt_upd;
      tgt_mot <= next_tgt_mot;
      tgt_pos <= next_tgt_pos;
      jump <= next_jump;
      jaddr <= next_jaddr;
      restore <= next_restore;
      rpc <= next_rpc;
      rflags <= next_rflags;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign irq_o = irq;
  assign tgt_upd_o = tgt_upd;
  assign tgt_motor_o = tgt_mot;
  assign tgt_pos_o = tgt_pos;
  assign jump_o = jump;
  assign jump_addr_o = jaddr;
  assign restore_o = restore;
  assign restore_pc_o = rpc;
  assign restore_flags_o = rflags;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_axis_write;
    ex && f_op == `ACX_OP_ACC2AXIS && f_bank < N_MOT && f_typ < N_AXP
      |=> axp[$past(axp_idx)] == $past(accu);
  endproperty
  a_axis_write: assert property (p_axis_write) else $error("axis parameter not written");
  property p_target;
    ex && f_op == `ACX_OP_ACC2AXIS && f_bank < N_MOT && f_typ == `ACX_AXP_TARGET
      |=> tgt_upd_o && tgt_pos_o == $past(accu) ##1 !tgt_upd_o;
  endproperty
  a_target: assert property (p_target) else $error("target position not updated");
  property p_user_var;
    ex && f_op == `ACX_OP_ACC2GLOBAL && f_bank == `ACX_BANK_USER && f_typ == `ACX_USER_VAR_EX
      |=> glb[N_GLB + `ACX_USER_VAR_EX] == $past(accu);
  endproperty
  a_user_var: assert property (p_user_var) else $error("user variable not written");
  property p_clr_all;
    ex && f_op == `ACX_OP_ERRCLR && f_typ == `ACX_CLR_ALL && err_set_i == '0 |=> err == '0;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("error flags not cleared");
  property p_clr_set_wins;
    ex && f_op == `ACX_OP_ERRCLR && f_typ == 8'h01 && err_set_i[0] |=> err[0];
  endproperty
  a_clr_set_wins: assert property (p_clr_set_wins) else $error("flag set lost to clear");
  property p_glb_on;
    ex && f_op == `ACX_OP_IRQEN && f_typ == `ACX_IRQ_GLOBAL |=> glb_en && src_en == $past(src_en);
  endproperty
  a_glb_on: assert property (p_glb_on) else $error("global enable not set");
  property p_glb_off;
    ex && f_op == `ACX_OP_IRQDIS && f_typ == `ACX_IRQ_GLOBAL |=> !glb_en;
  endproperty
  a_glb_off: assert property (p_glb_off) else $error("global enable not cleared");
  property p_src_en;
    ex && f_op == `ACX_OP_IRQEN && f_typ < N_IRQ |=> src_en[$past(typ_lo)];
  endproperty
  a_src_en: assert property (p_src_en) else $error("source not enabled");
  property p_irq_vector_define;
    ex && f_op == `ACX_OP_IRQVEC && f_typ < N_IRQ
      |=> vec_ok[$past(typ_lo)] && vec[$past(typ_lo)] == $past(val[VEC_W-1:0]);
  endproperty
  a_irq_vector_define: assert property (p_irq_vector_define) else $error("vector not stored");
  property p_reply;
    ex && !sa_mode && f_op == `ACX_OP_ERRCLR && f_typ == `ACX_CLR_ALL
      |=> rep_st == `ACX_ST_OK && state == ACX_IDLE;
  endproperty
  a_reply: assert property (p_reply) else $error("reply status wrong");
  property p_cksum;
    state == ACX_CHECK && !sa_mode && addr_ok && !sum_ok
      |=> state == ACX_IDLE && rep_st == `ACX_ST_CKSUM;
  endproperty
  a_cksum: assert property (p_cksum) else $error("bad checksum executed");
  property p_entry;
    jump_o |-> in_hdl && sv_accu == $past(accu) && sv_pc == $past(pc_i);
  endproperty
  a_entry: assert property (p_entry) else $error("context not saved");
  property p_return;
    ex && f_op == `ACX_OP_IRQRET && in_hdl |=> restore_o && accu == $past(sv_accu) && !in_hdl;
  endproperty
  a_return: assert property (p_return) else $error("context not restored");

  c_target: cover property (p_target);
  c_entry: cover property (jump_o ##[1:50] restore_o);
  c_cksum: cover property (state == ACX_CHECK && !sum_ok && !sa_mode);
endmodule // acx_cmd_exec

//--- logic/acx_consts.svh
// Constants of the accumulator transfer and interrupt command executor
`ifndef ACX_CONSTS_SVH
`define ACX_CONSTS_SVH
`define ACX_OP_ACC2AXIS 8'h22
`define ACX_OP_ACC2GLOBAL 8'h23
`define ACX_OP_ERRCLR 8'h24
`define ACX_OP_IRQEN 8'h19
`define ACX_OP_IRQDIS 8'h1a
`define ACX_OP_IRQVEC 8'h25
`define ACX_OP_IRQRET 8'h26
`define ACX_IRQ_GLOBAL 8'hff
`define ACX_ST_OK 8'h64
`define ACX_ST_CKSUM 8'h01
`define ACX_ST_BADCMD 8'h02
`define ACX_ST_BADTYPE 8'h03
`define ACX_ST_BADBANK 8'h04
`define ACX_BANK_BASIC 8'h00
`define ACX_BANK_USER 8'h02
`define ACX_BANK_IO 8'h03
`define ACX_USER_VAR_EX 8'h2a
`define ACX_AXP_TARGET 8'h00
`define ACX_CLR_ALL 8'h00
`define ACX_CLR_LAST 8'h05
`define ACX_REG_CTRL 8'h00
`define ACX_REG_HDR 8'h04
`define ACX_REG_VAL 8'h08
`define ACX_REG_CKS 8'h0c
`define ACX_REG_REPLY 8'h10
`define ACX_REG_ACCU 8'h18
`define ACX_REG_XREG 8'h1c
`define ACX_REG_ERR 8'h20
`define ACX_REG_IRQ_STAT 8'h24
`define ACX_REG_IRQ_MASK 8'h28
`define ACX_REG_INT_EN 8'h2c
`define ACX_REG_PSEL 8'h30
`define ACX_REG_PDATA 8'h34
`define ACX_CTRL_GO 0
`define ACX_CTRL_SA 1
`define ACX_PSEL_GLB 16
`define ACX_PSEL_VEC 17
`define ACX_EV_DONE 0
`define ACX_EV_CKSUM 1
`define ACX_EV_ENTRY 2
`define ACX_EV_ERR 3
`define ACX_EV_W 4
`define ACX_ERR_W 5
`define ACX_DEV_ADDR_RST 8'h01
`endif

//--- logic/acx_pkg.sv
// Types of the accumulator transfer and interrupt command executor
package acx_pkg;
  typedef enum logic [1:0] {ACX_IDLE, ACX_CHECK, ACX_EXEC} acx_state_type;
endpackage

//--- logic/acx_frame_chk.sv
// Frame checksum and target address check
`timescale 1ns/1ns
`include "acx_consts.svh"

module acx_frame_chk
  import acx_pkg::*;
#(
  parameter logic [7:0] DEV_ADDR = `ACX_DEV_ADDR_RST
) (
  input wire logic [31:0] hdr_i,
  input wire logic [31:0] val_i,
  input wire logic [7:0] cks_i,
  output logic sum_ok_o,
  output logic addr_ok_o
);
  logic [7:0] sum;

  // Modulo-256 sum, address first and value most significant byte first
  always_comb begin
    sum = 8'h00;
    for (int i = 3; i >= 0; i--) begin
      sum = sum + hdr_i[8*i +: 8];
    end
    for (int i = 3; i >= 0; i--) begin
      sum = sum + val_i[8*i +: 8];
    end
  end

  assign sum_ok_o = (sum == cks_i);
  assign addr_ok_o = (hdr_i[31:24] == DEV_ADDR);
endmodule // acx_frame_chk

//--- testbench/acx_host_model.sv
// Host model: Wishbone master that builds and sends command frames
`timescale 1ns/1ns
`include "acx_consts.svh"
module acx_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  // Held until ack is sampled; one idle cycle before the next
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o, we_o} <= 3'b000;
  endtask
  // Bad flips checksum bits; fixed wait covers the three-cycle execution
  task automatic send(input logic [7:0] code, input logic [7:0] typ, input logic [7:0] mb,
                      input logic [31:0] v, input logic [7:0] bad, input logic sa);
    logic [31:0] h;
    logic [7:0] s;
    logic [31:0] q;
    h = {`ACX_DEV_ADDR_RST, code, typ, mb};
    s = h[31:24] + h[23:16] + h[15:8] + h[7:0] + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    xfer(1'b1, `ACX_REG_HDR, h, q);
    xfer(1'b1, `ACX_REG_VAL, v, q);
    xfer(1'b1, `ACX_REG_CKS, {24'h0, s ^ bad}, q);
    xfer(1'b1, `ACX_REG_CTRL, {30'h0, sa, 1'b1}, q);
    repeat (6) @(posedge clk_i);
  endtask
endmodule // acx_host_model

//--- testbench/test_acx_cmd_exec.sv
// Self-checking bench for the command executor
`timescale 1ns/1ns
`include "acx_consts.svh"
module test_acx_cmd_exec;
  logic clk_i, rst_i, cyc, stb, we, ack, irq_o, tgt_upd_o, jump_o, restore_o;
  logic [7:0] adr, tgt_motor_o;
  logic [3:0] sel, flags_i, restore_flags_o;
  logic [31:0] wdat, rdat, tgt_pos_o, q;
  logic [4:0] err_set_i;
  logic [15:0] irq_src_i, pc_i, jump_addr_o, restore_pc_o;
  int err_count, samples_checked, cycles, n_upd, n_jump, n_rest;
  acx_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  acx_cmd_exec uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq_o), .err_set_i(err_set_i), .irq_src_i(irq_src_i),
    .pc_i(pc_i), .flags_i(flags_i), .tgt_upd_o(tgt_upd_o), .tgt_motor_o(tgt_motor_o),
    .tgt_pos_o(tgt_pos_o), .jump_o(jump_o), .jump_addr_o(jump_addr_o),
    .restore_o(restore_o), .restore_pc_o(restore_pc_o), .restore_flags_o(restore_flags_o));
  initial begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end
  // Pulses are counted so a missed or doubled pulse shows
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (tgt_upd_o === 1'b1) n_upd <= n_upd + 1;
    if (jump_o === 1'b1) n_jump <= n_jump + 1;
    if (restore_o === 1'b1) n_rest <= n_rest + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic t_axis;
    wr(`ACX_REG_ACCU, 32'h1234_5678);
    host.send(`ACX_OP_ACC2AXIS, `ACX_AXP_TARGET, 8'h02, 32'h0, 8'h0, 1'b0);
    chk(n_upd, 1);
    chk(tgt_pos_o, 32'h1234_5678);
    chk(tgt_motor_o, 32'h2);
    rd_chk(`ACX_REG_REPLY, 32'h0000_2264);
    host.send(`ACX_OP_ACC2AXIS, 8'h03, 8'h01, 32'h0, 8'h0, 1'b0);
    chk(n_upd, 1);
    wr(`ACX_REG_PSEL, 32'h0000_0103);
    rd_chk(`ACX_REG_PDATA, 32'h1234_5678);
    // Corrupt checksum: nothing runs
    host.send(`ACX_OP_ACC2AXIS, 8'h00, 8'h00, 32'h0, 8'h01, 1'b0);
    chk(n_upd, 1);
    rd_chk(`ACX_REG_REPLY, 32'h0000_2201);
    // Frame for another address: dropped without a reply
    wr(`ACX_REG_HDR, 32'h0222_0000);
    wr(`ACX_REG_VAL, 32'h0);
    wr(`ACX_REG_CKS, 32'h24);
    wr(`ACX_REG_CTRL, 32'h1);
    repeat (6) @(posedge clk_i);
    chk(n_upd, 1);
    rd_chk(`ACX_REG_REPLY, 32'h0000_2201);
  endtask
  task automatic t_global;
    for (int i = 0; i < 3; i++) begin
      wr(`ACX_REG_ACCU, 32'h100 + i);
      host.send(`ACX_OP_ACC2GLOBAL, `ACX_USER_VAR_EX, 8'(i == 0 ? 0 : i + 1), 32'hdead_beef,
                8'h0, 1'b0);
      wr(`ACX_REG_PSEL, {15'h0, 1'b1, 8'(i), `ACX_USER_VAR_EX});
      rd_chk(`ACX_REG_PDATA, 32'h100 + i);
    end
    // Bank 1 is not a global bank
    host.send(`ACX_OP_ACC2GLOBAL, `ACX_USER_VAR_EX, 8'h1, 32'h0, 8'h0, 1'b0);
    rd_chk(`ACX_REG_REPLY, 32'h0000_2304);
  endtask
  task automatic t_err;
    wr(`ACX_REG_IRQ_STAT, 32'hf);
    wr(`ACX_REG_IRQ_MASK, 32'h8);
    @(posedge clk_i) err_set_i <= 5'h1f;
    @(posedge clk_i) err_set_i <= 5'h00;
    for (int k = 1; k <= 5; k++) begin
      host.send(`ACX_OP_ERRCLR, 8'(k), 8'h3, 32'h7, 8'h0, 1'b0);
      rd_chk(`ACX_REG_ERR, 32'h1f & ~((32'h1 << k) - 1));
    end
    chk(irq_o, 1);
    wr(`ACX_REG_IRQ_STAT, 32'h8);
    rd_chk(`ACX_REG_IRQ_STAT, 32'h1);
    chk(irq_o, 0);
    // Flag held set through its own clear: the set wins
    @(posedge clk_i) err_set_i <= 5'h01;
    host.send(`ACX_OP_ERRCLR, 8'h1, 8'h0, 32'h0, 8'h0, 1'b0);
    err_set_i <= 5'h00;
    rd_chk(`ACX_REG_ERR, 32'h1);
    @(posedge clk_i) err_set_i <= 5'h1f;
    @(posedge clk_i) err_set_i <= 5'h00;
    host.send(`ACX_OP_ERRCLR, `ACX_CLR_ALL, 8'h0, 32'h0, 8'h0, 1'b0);
    rd_chk(`ACX_REG_ERR, 32'h0);
  endtask
  task automatic t_enable;
    host.send(`ACX_OP_IRQEN, 8'h3, 8'h4, 32'h9, 8'h0, 1'b0);
    rd_chk(`ACX_REG_INT_EN, 32'h0000_0008);
    host.send(`ACX_OP_IRQEN, `ACX_IRQ_GLOBAL, 8'h0, 32'h0, 8'h0, 1'b0);
    rd_chk(`ACX_REG_INT_EN, 32'h8000_0008);
    host.send(`ACX_OP_IRQDIS, 8'h3, 8'h4, 32'h9, 8'h0, 1'b0);
    rd_chk(`ACX_REG_INT_EN, 32'h8000_0000);
    host.send(`ACX_OP_IRQDIS, `ACX_IRQ_GLOBAL, 8'h0, 32'h0, 8'h0, 1'b0);
    rd_chk(`ACX_REG_INT_EN, 32'h0);
  endtask
  // Vector define is sent only in standalone mode
  task automatic t_vector;
    host.send(`ACX_OP_IRQVEC, 8'h3, 8'h0, 32'h50, 8'h0, 1'b1);
    host.send(`ACX_OP_IRQVEC, 8'h3, 8'h0, 32'h60, 8'h0, 1'b1);
    wr(`ACX_REG_PSEL, 32'h0002_0003);
    rd_chk(`ACX_REG_PDATA, 32'h60);
    host.send(`ACX_OP_IRQEN, 8'h3, 8'h0, 32'h0, 8'h0, 1'b1);
    host.send(`ACX_OP_IRQEN, `ACX_IRQ_GLOBAL, 8'h0, 32'h0, 8'h0, 1'b1);
    wr(`ACX_REG_ACCU, 32'h77);
    wr(`ACX_REG_XREG, 32'h55);
    @(posedge clk_i) irq_src_i <= 16'h0008;
    @(posedge clk_i) irq_src_i <= 16'h0000;
    repeat (4) @(posedge clk_i);
    chk(n_jump, 1);
    chk(jump_addr_o, 32'h60);
    wr(`ACX_REG_ACCU, 32'h99);
    wr(`ACX_REG_XREG, 32'haa);
    host.send(`ACX_OP_IRQRET, `ACX_IRQ_GLOBAL, 8'h0, 32'h0, 8'h0, 1'b1);
    chk(n_rest, 1);
    chk({restore_flags_o, restore_pc_o}, 32'h5_0abc);
    rd_chk(`ACX_REG_ACCU, 32'h77);
    rd_chk(`ACX_REG_XREG, 32'h55);
  endtask
  initial begin
    rst_i = 1;
    {err_set_i, irq_src_i} = '0;
    pc_i = 16'h0abc;
    flags_i = 4'h5;
    {n_upd, n_jump, n_rest, err_count, samples_checked, cycles} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rd_chk(8'hfc, 32'h0);
    t_axis();
    t_global();
    t_err();
    t_enable();
    t_vector();
    report_and_stop();
  end
endmodule // test_acx_cmd_exec
